// ==== apc_pkg.sv ====
package apc_pkg;

  // ----------------------------------------
  // Framing bytes and type codes
  // ----------------------------------------
  localparam logic [7:0] FRAME_DELIM   = 8'h7e;
  localparam logic [7:0] ESC_BYTE      = 8'h7d;
  localparam logic [7:0] ESC_XOR       = 8'h20;
  localparam logic [7:0] XON_BYTE      = 8'h11;
  localparam logic [7:0] XOFF_BYTE     = 8'h13;
  localparam logic [7:0] CSUM_GOOD     = 8'hff;
  localparam logic [7:0] TYPE_IMM      = 8'h08;
  localparam logic [7:0] TYPE_QUEUED   = 8'h09;
  localparam logic [7:0] TYPE_CMD_RESP = 8'h88;
  localparam logic [7:0] TYPE_TX_STAT  = 8'h89;
  localparam logic [7:0] TYPE_MODEM    = 8'h8a;
  localparam logic [7:0] MODEM_READY   = 8'h00;

  // ----------------------------------------
  // Response status codes
  // ----------------------------------------
  localparam logic [7:0] ST_OK        = 8'h00;
  localparam logic [7:0] ST_BAD_CMD   = 8'h02;
  localparam logic [7:0] ST_BAD_PARAM = 8'h03;

  // ----------------------------------------
  // Parameter table layout
  // ----------------------------------------
  localparam int          NPARAM       = 8;
  localparam logic [2:0]  LAST_IDX     = 3'h7;
  localparam logic [2:0]  MODE_IDX     = 3'h0;
  localparam logic [15:0] NAME_APPLY   = 16'h4143;
  localparam logic [7:0]  MODE_RST     = 8'h01;
  localparam logic [7:0]  MODE_ESCAPED = 8'h02;
  localparam logic [7:0]  HDR_BYTES    = 8'h04;
  localparam logic [15:0] MIN_LEN      = 16'h0004;
  localparam logic [15:0] ONE_VALUE    = 16'h0005;
  localparam logic [7:0]  RESP_LEN     = 8'h05;
  localparam logic [7:0]  RESP_LEN_VAL = 8'h06;
  localparam logic [7:0]  MODEM_LEN    = 8'h02;

  typedef enum logic [3:0] {
    R_INIT  = 4'h0, R_HUNT  = 4'h1, R_LENH   = 4'h2, R_LENL = 4'h3,
    R_DATA  = 4'h4, R_CSUM  = 4'h5, R_LOOK   = 4'h6, R_RDWAIT = 4'h7,
    R_APPLY = 4'h8, R_RESP  = 4'h9
  } apc_rx_st_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_LENH = 3'h1, T_LENL = 3'h2, T_DATA = 3'h3,
    T_CSUM = 3'h4, T_LAST = 3'h5
  } apc_tx_st_t;

  // Name lookup: bit 3 is hit, bits 2:0 the table index
  function automatic logic [3:0] name_lookup(input logic [15:0] nm);
    unique case (nm)
      16'h4150: name_lookup = 4'h8;
      16'h4244: name_lookup = 4'h9;
      16'h4e42: name_lookup = 4'ha;
      16'h5342: name_lookup = 4'hb;
      16'h524f: name_lookup = 4'hc;
      16'h4754: name_lookup = 4'hd;
      16'h4343: name_lookup = 4'he;
      16'h444f: name_lookup = 4'hf;
      default:  name_lookup = 4'h0;
    endcase
  endfunction

  // Value check per parameter
  function automatic logic value_ok(input logic [2:0] idx, input logic [7:0] v);
    value_ok = (idx != MODE_IDX) || (v <= MODE_ESCAPED);
  endfunction

  // Bytes that must be escaped on the wire
  function automatic logic needs_escape(input logic [7:0] b);
    needs_escape = (b == FRAME_DELIM) || (b == ESC_BYTE) ||
                   (b == XON_BYTE) || (b == XOFF_BYTE);
  endfunction

endpackage

// ==== apc_mem_if.sv ====
`timescale 1ns/1ps
interface apc_mem_if;
  logic       wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface

// ==== apc_param_mem.sv ====
`timescale 1ns/1ps
module apc_param_mem (
  input  wire logic   mclk_in,
  apc_mem_if.store    mif
);

  // ----------------------------------------
  // Live values 0-7, pending values 8-15
  // ----------------------------------------
  logic [7:0] mem_ff [16];
  logic [7:0] rd_ff;

  // Write port and registered read
  always_ff @(posedge mclk_in) begin
    if (mif.wr_en) begin
      mem_ff[mif.wr_addr] <= mif.wr_data;
    end
    rd_ff <= mem_ff[mif.rd_addr];
  end

  assign mif.rd_data = rd_ff;

endmodule

// ==== apc_param_cmd.sv ====
// Contract
// R1 - Type 0x08 frames are local parameter query or set requests.
// R2 - Immediate set takes effect once executed, no further frame needed.
// R3 - Reference byte zero: execute but send no response.
// R4 - Host's reference byte is echoed in the matching response.
// R5 - Host names the parameter with two ASCII bytes after the reference.
// R6 - Value bytes after the name mean write the parameter.
// R7 - No value bytes means read and report the current value.
// R8 - Type 0x09 frames hold new values pending.
// R9 - Pending values apply on an immediate frame or apply command.
// R10 - Reads in queued frames are answered at once.
// R11 - Responses to both frame types use type 0x88.
// R12 - Transmit status and modem status use their own type codes; the code never sends transmit status, only modem status 0x8A.
// R13 - Frame is delimiter, big-endian length, data, checksum.
// R14 - Checksum is 0xFF minus data sum; bad frames are ignored.
// R15 - Escaped mode escapes 7E 7D 11 13 with 7D and XOR 0x20.
// R16 - Bytes before a delimiter dropped; escaped delimiter restarts frame.
// R17 - Bad name or value reports error status and changes nothing; immediate frames and apply commands still apply pending values first.
`timescale 1ns/1ps
module apc_param_cmd (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       rx_valid_in,
  output logic            rx_ready_out,
  output logic [7:0]      tx_data_out,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  output logic [7:0]      api_mode_out
);

  apc_mem_if mif ();

  apc_param_mem u_mem (
    .mclk_in (mclk_in),
    .mif     (mif)
  );

  // ----------------------------------------
  // Receive and execute state
  // ----------------------------------------
  apc_pkg::apc_rx_st_t st_ff, nxt_st;
  logic [15:0] len_ff, nxt_len, cnt_ff, nxt_cnt;
  logic [7:0]  sum_ff, nxt_sum, mode_ff, nxt_mode;
  logic [7:0]  buf_ff [5];
  logic [7:0]  nxt_buf [5];
  logic [7:0]  pend_ff, nxt_pend, stat_ff, nxt_stat, val_ff, nxt_val;
  logic [2:0]  k_ff, nxt_k;
  logic        esc_ff, nxt_esc, ph_ff, nxt_ph, applied_ff, nxt_applied;
  logic        hasval_ff, nxt_hasval, modem_ff, nxt_modem;
  logic        go_ff, nxt_go, rdy_ff, nxt_rdy;
  logic        take, esc_mode, is_write;
  logic [7:0]  d;
  logic [3:0]  hit;
  logic [15:0] vlen;
  apc_pkg::apc_tx_st_t tst_ff;

  assign take     = rx_valid_in && rdy_ff;
  assign esc_mode = (mode_ff == apc_pkg::MODE_ESCAPED);
  assign d        = esc_ff ? (rx_data_in ^ apc_pkg::ESC_XOR) : rx_data_in;
  assign hit      = apc_pkg::name_lookup({buf_ff[2], buf_ff[3]}); // R5
  assign vlen     = len_ff - apc_pkg::MIN_LEN;
  assign is_write = (vlen != 16'h0000); // R6

  // Frame parse, lookup, apply and response launch
  always_comb begin
    nxt_st = st_ff; nxt_len = len_ff; nxt_cnt = cnt_ff; nxt_sum = sum_ff;
    nxt_mode = mode_ff; nxt_buf = buf_ff; nxt_pend = pend_ff; nxt_stat = stat_ff;
    nxt_val = val_ff; nxt_k = k_ff; nxt_esc = esc_ff; nxt_ph = ph_ff;
    nxt_applied = applied_ff; nxt_hasval = hasval_ff; nxt_modem = modem_ff;
    nxt_go = 1'b0;
    mif.wr_en = 1'b0; mif.wr_addr = 4'h0; mif.wr_data = 8'h00;
    mif.rd_addr = {1'b1, k_ff};
    unique case (st_ff)
      apc_pkg::R_INIT: begin
        mif.wr_en   = 1'b1;
        mif.wr_addr = {1'b0, k_ff};
        mif.wr_data = (k_ff == apc_pkg::MODE_IDX) ? apc_pkg::MODE_RST : 8'h00;
        nxt_k       = k_ff + 3'h1;
        if (k_ff == apc_pkg::LAST_IDX) begin
          nxt_modem = 1'b1; // R12
          nxt_st    = apc_pkg::R_RESP;
        end
      end
      apc_pkg::R_HUNT: begin
        if (take && rx_data_in == apc_pkg::FRAME_DELIM) begin // R16
          nxt_st  = apc_pkg::R_LENH;
          nxt_esc = 1'b0;
        end
      end
      apc_pkg::R_LENH, apc_pkg::R_LENL, apc_pkg::R_DATA, apc_pkg::R_CSUM: begin
        if (take) begin
          if (esc_mode && rx_data_in == apc_pkg::FRAME_DELIM) begin // R16
            nxt_st  = apc_pkg::R_LENH;
            nxt_esc = 1'b0;
          end else if (esc_mode && !esc_ff && rx_data_in == apc_pkg::ESC_BYTE) begin
            nxt_esc = 1'b1; // R15
          end else begin
            nxt_esc = 1'b0;
            unique case (st_ff)
              apc_pkg::R_LENH: begin
                nxt_len[15:8] = d; // R13
                nxt_st        = apc_pkg::R_LENL;
              end
              apc_pkg::R_LENL: begin
                nxt_len[7:0] = d;
                nxt_cnt      = 16'h0000;
                nxt_sum      = 8'h00;
                nxt_st       = ({len_ff[15:8], d} == 16'h0000) ? apc_pkg::R_CSUM
                                                               : apc_pkg::R_DATA;
              end
              apc_pkg::R_DATA: begin
                nxt_sum = sum_ff + d;
                if (cnt_ff < 16'h0005) begin
                  nxt_buf[cnt_ff[2:0]] = d;
                end
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_ff == len_ff - 16'h0001) begin
                  nxt_st = apc_pkg::R_CSUM;
                end
              end
              default: begin
                nxt_st      = apc_pkg::R_HUNT;
                nxt_applied = 1'b0;
                nxt_hasval  = 1'b0;
                nxt_modem   = 1'b0;
                if ((sum_ff + d) == apc_pkg::CSUM_GOOD && len_ff >= apc_pkg::MIN_LEN &&
                    (buf_ff[0] == apc_pkg::TYPE_IMM ||
                     buf_ff[0] == apc_pkg::TYPE_QUEUED)) begin // R1 R14
                  nxt_st = apc_pkg::R_LOOK;
                end
              end
            endcase
          end
        end
      end
      apc_pkg::R_LOOK: begin
        nxt_stat = apc_pkg::ST_OK;
        nxt_st   = apc_pkg::R_RESP;
        if (pend_ff != 8'h00 && !applied_ff &&
            (buf_ff[0] == apc_pkg::TYPE_IMM ||
             {buf_ff[2], buf_ff[3]} == apc_pkg::NAME_APPLY)) begin // R9
          nxt_k  = 3'h0;
          nxt_ph = 1'b0;
          nxt_st = apc_pkg::R_APPLY;
        end else if ({buf_ff[2], buf_ff[3]} == apc_pkg::NAME_APPLY) begin
          if (is_write) nxt_stat = apc_pkg::ST_BAD_PARAM; // R17
        end else if (!hit[3]) begin
          nxt_stat = apc_pkg::ST_BAD_CMD; // R17
        end else if (!is_write) begin
          mif.rd_addr = {1'b0, hit[2:0]}; // R7 R10
          nxt_st      = apc_pkg::R_RDWAIT;
        end else if (len_ff != apc_pkg::ONE_VALUE ||
                     !apc_pkg::value_ok(hit[2:0], buf_ff[4])) begin
          nxt_stat = apc_pkg::ST_BAD_PARAM; // R17
        end else if (buf_ff[0] == apc_pkg::TYPE_QUEUED) begin
          mif.wr_en              = 1'b1; // R8
          mif.wr_addr            = {1'b1, hit[2:0]};
          mif.wr_data            = buf_ff[4];
          nxt_pend[hit[2:0]]     = 1'b1;
        end else begin
          mif.wr_en   = 1'b1; // R2 R6
          mif.wr_addr = {1'b0, hit[2:0]};
          mif.wr_data = buf_ff[4];
          if (hit[2:0] == apc_pkg::MODE_IDX) nxt_mode = buf_ff[4];
        end
      end
      apc_pkg::R_RDWAIT: begin
        nxt_val    = mif.rd_data;
        nxt_hasval = 1'b1;
        nxt_st     = apc_pkg::R_RESP;
      end
      apc_pkg::R_APPLY: begin
        if (ph_ff) begin
          mif.wr_en     = 1'b1; // R9
          mif.wr_addr   = {1'b0, k_ff};
          mif.wr_data   = mif.rd_data;
          nxt_pend[k_ff] = 1'b0;
          if (k_ff == apc_pkg::MODE_IDX) nxt_mode = mif.rd_data;
          nxt_ph = 1'b0;
        end else if (pend_ff[k_ff]) begin
          nxt_ph = 1'b1;
        end
        if (ph_ff || !pend_ff[k_ff]) begin
          nxt_k = k_ff + 3'h1;
          if (k_ff == apc_pkg::LAST_IDX) begin
            nxt_applied = 1'b1;
            nxt_st      = apc_pkg::R_LOOK;
          end
        end
      end
      apc_pkg::R_RESP: begin
        if (!modem_ff && buf_ff[1] == 8'h00) begin
          nxt_st = apc_pkg::R_HUNT; // R3
        end else if (tst_ff == apc_pkg::T_IDLE) begin
          nxt_go = 1'b1;
          nxt_st = apc_pkg::R_HUNT;
        end
      end
      default: nxt_st = apc_pkg::R_HUNT;
    endcase
    nxt_rdy = (nxt_st == apc_pkg::R_HUNT) || (nxt_st == apc_pkg::R_LENH) ||
              (nxt_st == apc_pkg::R_LENL) || (nxt_st == apc_pkg::R_DATA) ||
              (nxt_st == apc_pkg::R_CSUM);
  end

  // Receive and execute registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_ff <= apc_pkg::R_INIT; len_ff <= 16'h0000; cnt_ff <= 16'h0000;
      sum_ff <= 8'h00; mode_ff <= apc_pkg::MODE_RST; pend_ff <= 8'h00;
      stat_ff <= 8'h00; val_ff <= 8'h00; k_ff <= 3'h0; esc_ff <= 1'b0;
      ph_ff <= 1'b0; applied_ff <= 1'b0; hasval_ff <= 1'b0; modem_ff <= 1'b0;
      go_ff <= 1'b0; rdy_ff <= 1'b0;
      for (int i = 0; i < 5; i++) buf_ff[i] <= 8'h00;
    end else begin
      st_ff <= nxt_st; len_ff <= nxt_len; cnt_ff <= nxt_cnt; sum_ff <= nxt_sum;
      mode_ff <= nxt_mode; pend_ff <= nxt_pend; stat_ff <= nxt_stat;
      val_ff <= nxt_val; k_ff <= nxt_k; esc_ff <= nxt_esc; ph_ff <= nxt_ph;
      applied_ff <= nxt_applied; hasval_ff <= nxt_hasval; modem_ff <= nxt_modem;
      go_ff <= nxt_go; rdy_ff <= nxt_rdy; buf_ff <= nxt_buf;
    end
  end

  // ----------------------------------------
  // Transmit framer
  // ----------------------------------------
  apc_pkg::apc_tx_st_t nxt_tst;
  logic [7:0] tbuf_ff [6];
  logic [7:0] nxt_tbuf [6];
  logic [7:0] tlen_ff, nxt_tlen, tsum_ff, nxt_tsum, tdat_ff, nxt_tdat;
  logic [7:0] epend_ff, nxt_epend, raw;
  logic [2:0] ti_ff, nxt_ti;
  logic       tval_ff, nxt_tval, hasep_ff, nxt_hasep, isdl_ff, nxt_isdl, adv;

  assign adv = !tval_ff || tx_ready_in;

  // Output byte sequencing with escape insertion
  always_comb begin
    nxt_tst = tst_ff; nxt_tbuf = tbuf_ff; nxt_tlen = tlen_ff; nxt_tsum = tsum_ff;
    nxt_tdat = tdat_ff; nxt_epend = epend_ff; nxt_ti = ti_ff; nxt_tval = tval_ff;
    nxt_hasep = hasep_ff; nxt_isdl = isdl_ff;
    raw = 8'h00;
    if (tst_ff == apc_pkg::T_IDLE) begin
      if (go_ff && adv) begin
        if (modem_ff) begin
          nxt_tbuf[0] = apc_pkg::TYPE_MODEM; // R12
          nxt_tbuf[1] = apc_pkg::MODEM_READY;
          nxt_tlen    = apc_pkg::MODEM_LEN;
        end else begin
          nxt_tbuf[0] = apc_pkg::TYPE_CMD_RESP; // R11
          nxt_tbuf[1] = buf_ff[1]; // R4
          nxt_tbuf[2] = buf_ff[2];
          nxt_tbuf[3] = buf_ff[3];
          nxt_tbuf[4] = stat_ff;
          nxt_tbuf[5] = val_ff;
          nxt_tlen    = hasval_ff ? apc_pkg::RESP_LEN_VAL : apc_pkg::RESP_LEN;
        end
        nxt_tdat = apc_pkg::FRAME_DELIM; // R13
        nxt_tval = 1'b1;
        nxt_isdl = 1'b1;
        nxt_tsum = 8'h00;
        nxt_ti   = 3'h0;
        nxt_tst  = apc_pkg::T_LENH;
      end else if (adv) begin
        nxt_tval = 1'b0;
      end
    end else if (adv) begin
      nxt_tval = 1'b1;
      nxt_isdl = 1'b0;
      if (hasep_ff) begin
        nxt_tdat  = epend_ff;
        nxt_hasep = 1'b0;
      end else if (tst_ff == apc_pkg::T_LAST) begin
        nxt_tval = 1'b0;
        nxt_tst  = apc_pkg::T_IDLE;
      end else begin
        unique case (tst_ff)
          apc_pkg::T_LENH: begin
            raw     = 8'h00;
            nxt_tst = apc_pkg::T_LENL;
          end
          apc_pkg::T_LENL: begin
            raw     = tlen_ff;
            nxt_tst = apc_pkg::T_DATA;
          end
          apc_pkg::T_DATA: begin
            raw      = tbuf_ff[ti_ff];
            nxt_tsum = tsum_ff + raw;
            nxt_ti   = ti_ff + 3'h1;
            if ({5'h00, ti_ff} == tlen_ff - 8'h01) nxt_tst = apc_pkg::T_CSUM;
          end
          default: begin
            raw     = apc_pkg::CSUM_GOOD - tsum_ff; // R14
            nxt_tst = apc_pkg::T_LAST;
          end
        endcase
        if (mode_ff == apc_pkg::MODE_ESCAPED && apc_pkg::needs_escape(raw)) begin
          nxt_tdat  = apc_pkg::ESC_BYTE; // R15
          nxt_epend = raw ^ apc_pkg::ESC_XOR;
          nxt_hasep = 1'b1;
        end else begin
          nxt_tdat = raw;
        end
      end
    end
  end

  // Transmit registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tst_ff <= apc_pkg::T_IDLE; tlen_ff <= 8'h00; tsum_ff <= 8'h00;
      tdat_ff <= 8'h00; epend_ff <= 8'h00; ti_ff <= 3'h0; tval_ff <= 1'b0;
      hasep_ff <= 1'b0; isdl_ff <= 1'b0;
      for (int i = 0; i < 6; i++) tbuf_ff[i] <= 8'h00;
    end else begin
      tst_ff <= nxt_tst; tlen_ff <= nxt_tlen; tsum_ff <= nxt_tsum;
      tdat_ff <= nxt_tdat; epend_ff <= nxt_epend; ti_ff <= nxt_ti;
      tval_ff <= nxt_tval; hasep_ff <= nxt_hasep; isdl_ff <= nxt_isdl;
      tbuf_ff <= nxt_tbuf;
    end
  end

  assign rx_ready_out = rdy_ff;
  assign tx_data_out  = tdat_ff;
  assign tx_valid_out = tval_ff;
  assign api_mode_out = mode_ff;

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_resp_type_code: assert property (go_ff && !modem_ff && adv |=> // R11
    tbuf_ff[0] == apc_pkg::TYPE_CMD_RESP && tdat_ff == apc_pkg::FRAME_DELIM)
    else $error("command response type wrong");
  a_ref_echo: assert property (go_ff && !modem_ff && adv |=> // R4
    tbuf_ff[1] == $past(buf_ff[1]))
    else $error("reference byte not echoed");
  a_ref_zero_quiet: assert property ((st_ff == apc_pkg::R_RESP && !modem_ff && // R3
    buf_ff[1] == 8'h00) |=> !go_ff ##1 tst_ff == apc_pkg::T_IDLE)
    else $error("response sent for zero reference");
  a_queue_pending: assert property ((st_ff == apc_pkg::R_LOOK && mif.wr_en && // R8
    buf_ff[0] == apc_pkg::TYPE_QUEUED) |-> mif.wr_addr[3] ##1 pend_ff != 8'h00)
    else $error("queued value not held pending");
  a_imm_applied: assert property ((st_ff == apc_pkg::R_RESP && !modem_ff && // R9
    buf_ff[0] == apc_pkg::TYPE_IMM) |-> pend_ff == 8'h00)
    else $error("pending left after immediate frame");
  a_read_at_once: assert property ((st_ff == apc_pkg::R_LOOK && !is_write && // R10
    hit[3] && (applied_ff || pend_ff == 8'h00 || buf_ff[0] == apc_pkg::TYPE_QUEUED))
    |=> st_ff == apc_pkg::R_RDWAIT ##1 st_ff == apc_pkg::R_RESP && hasval_ff)
    else $error("read not answered at once");
  a_bad_csum_drop: assert property ((st_ff == apc_pkg::R_CSUM && take && // R14
    !(esc_mode && (rx_data_in == apc_pkg::ESC_BYTE || rx_data_in == apc_pkg::FRAME_DELIM))
    && (sum_ff + d) != apc_pkg::CSUM_GOOD) |=> st_ff == apc_pkg::R_HUNT)
    else $error("bad checksum frame accepted");
  a_hunt_discard: assert property ((st_ff == apc_pkg::R_HUNT && take && // R16
    rx_data_in != apc_pkg::FRAME_DELIM) |=> st_ff == apc_pkg::R_HUNT)
    else $error("byte before delimiter not dropped");
  a_tx_escaped: assert property ((tval_ff && !isdl_ff && // R15
    mode_ff == apc_pkg::MODE_ESCAPED) |-> tdat_ff != apc_pkg::FRAME_DELIM)
    else $error("unescaped delimiter in frame body");

  c_imm_write: cover property (st_ff == apc_pkg::R_LOOK && mif.wr_en && !mif.wr_addr[3]);
  c_queued_write: cover property (st_ff == apc_pkg::R_LOOK && mif.wr_en && mif.wr_addr[3]);
  c_apply_done: cover property (st_ff == apc_pkg::R_APPLY && nxt_applied && !applied_ff);
  c_escaped_out: cover property (tval_ff && hasep_ff && tx_ready_in);

endmodule

// ==== apc_host_model.sv ====
`timescale 1ns/1ps
module apc_host_model (
  input  wire logic       mclk_in,
  input  wire logic       rx_ready_in,
  input  wire logic       slow_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            tx_ready_out
);
  logic [1:0] stall_ff;

  // Idle line values at time zero
  initial begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
    stall_ff     = 2'h0;
  end

  // Sink takes one byte in four when slow
  always @(posedge mclk_in) begin
    stall_ff     <= stall_ff + 2'h1;
    tx_ready_out <= !slow_in || (stall_ff == 2'h0);
  end

  // Offer a byte and hold it until the device takes it
  task automatic send_byte(input logic [7:0] b);
    int n;
    rx_data_out  <= b;
    rx_valid_out <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (!rx_ready_in && n < 3000);
    if (n >= 3000) api_param_cmd_frames_tb_top.hang();
  endtask

  // Release the line; data shows the inverse of the last byte
  task automatic rel();
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~rx_data_out;
    @(posedge mclk_in); // One idle edge before the next frame
  endtask
endmodule

// ==== api_param_cmd_frames_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module api_param_cmd_frames_tb_top;
  typedef logic [7:0] apc_bq_t[$];
  logic        mclk_in, sys_rst_in, rx_valid, rx_ready, tx_valid, tx_ready, slow, esc;
  logic [7:0]  rx_data, tx_data, api_mode, eb, v;
  logic [7:0]  exp_q[$];
  logic [31:0] seed;
  int          mismatches, num_checks;

  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  apc_param_cmd uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .api_mode_out(api_mode));
  apc_host_model host (.mclk_in(mclk_in), .rx_ready_in(rx_ready), .slow_in(slow),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // One byte to the wire or the expect queue, escaped in mode 2
  task automatic put(input logic [7:0] b, input bit tx);
    if (esc && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
      if (tx) exp_q.push_back(8'h7d);
      else host.send_byte(8'h7d);
      b = b ^ 8'h20;
    end
    if (tx) exp_q.push_back(b);
    else host.send_byte(b);
  endtask

  // Delimiter, length, data, checksum
  task automatic frame(input apc_bq_t d, input bit tx, input bit bad);
    logic [7:0] cs;
    cs = 8'hff;
    foreach (d[i]) cs = cs - d[i];
    if (tx) exp_q.push_back(8'h7e);
    else host.send_byte(8'h7e);
    put(8'h00, tx);
    put(8'(d.size()), tx);
    foreach (d[i]) put(d[i], tx);
    put(cs ^ {7'h0, bad}, tx);
    if (!tx) host.rel();
  endtask

  // Send a command and note the response it should bring
  task automatic cmd(input logic [7:0] ty, rf, input logic [15:0] nm, input bit wr,
                     input logic [7:0] wv, st, input bit rd, input logic [7:0] rv);
    apc_bq_t d, r;
    d = {ty, rf, nm[15:8], nm[7:0]};
    if (wr) d.push_back(wv);
    frame(d, 1'b0, 1'b0);
    if (nm == 16'h4150 && wr && st == 8'h00 && ty == 8'h08) esc = (wv == 8'h02);
    r = {8'h88, rf, nm[15:8], nm[7:0], st};
    if (rd) r.push_back(rv);
    if (rf != 8'h00) frame(r, 1'b1, 1'b0);
  endtask

  task automatic drain(input string nm);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 5000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 5000) hang();
    repeat (40) @(posedge mclk_in);
    `CHK("bytes missing", 0, exp_q.size())
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("unexpected wait exp done got timeout");
    tally_and_finish();
  endtask

  // Watcher: each byte taken is matched to the oldest note
  always @(posedge mclk_in) begin
    if (!sys_rst_in && tx_valid === 1'b1 && tx_ready) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("unexpected tx byte exp none got %h", tx_data);
      end else begin
        eb = exp_q.pop_front();
        `CHK("tx byte", eb, tx_data)
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    slow = 1'b0;
    esc = 1'b0;
    seed = 32'h58ec;
    mismatches = 0;
    num_checks = 0;
    frame({8'h8a, 8'h00}, 1'b1, 1'b0);
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    `CHK("ready in init", 1'b0, rx_ready)
    drain("startup");
    `CHK("ready idle", 1'b1, rx_ready)
    cmd(8'h08, 8'h01, 16'h4150, 0, 8'h00, 8'h00, 1, 8'h01);
    drain("read");
    slow <= 1'b1;
    seed = xs(seed);
    v = seed[7:0];
    cmd(8'h08, 8'h02, 16'h4244, 1, v, 8'h00, 0, 8'h00);
    cmd(8'h08, 8'h03, 16'h4244, 0, 8'h00, 8'h00, 1, v);
    drain("write");
    seed = xs(seed);
    slow <= seed[8];
    v = seed[7:0];
    cmd(8'h09, 8'h04, 16'h4e42, 1, v, 8'h00, 0, 8'h00);
    cmd(8'h09, 8'h05, 16'h4e42, 0, 8'h00, 8'h00, 1, 8'h00);
    cmd(8'h08, 8'h06, 16'h4143, 0, 8'h00, 8'h00, 0, 8'h00);
    cmd(8'h08, 8'h07, 16'h4e42, 0, 8'h00, 8'h00, 1, v);
    cmd(8'h09, 8'h08, 16'h5342, 1, ~v, 8'h00, 0, 8'h00);
    cmd(8'h08, 8'h09, 16'h5a5a, 0, 8'h00, 8'h02, 0, 8'h00);
    cmd(8'h08, 8'h0a, 16'h5342, 0, 8'h00, 8'h00, 1, ~v);
    drain("queued");
    cmd(8'h08, 8'h00, 16'h524f, 1, 8'h3c, 8'h00, 0, 8'h00);
    cmd(8'h08, 8'h0b, 16'h524f, 0, 8'h00, 8'h00, 1, 8'h3c);
    host.send_byte(8'h55);
    host.send_byte(8'h41);
    frame({8'h08, 8'h0c, 8'h41, 8'h50}, 1'b0, 1'b1);
    cmd(8'h08, 8'h0d, 16'h4150, 1, 8'h05, 8'h03, 0, 8'h00);
    drain("refused");
    `CHK("mode kept", 8'h01, api_mode)
    cmd(8'h08, 8'h11, 16'h4150, 1, 8'h02, 8'h00, 0, 8'h00);
    drain("mode");
    `CHK("mode set", 8'h02, api_mode)
    host.send_byte(8'h7e);
    host.send_byte(8'h00);
    cmd(8'h08, 8'h13, 16'h4754, 1, 8'h7d, 8'h00, 0, 8'h00);
    cmd(8'h09, 8'h0e, 16'h4754, 0, 8'h00, 8'h00, 1, 8'h7d);
    drain("escaped");
    tally_and_finish();
  end
endmodule
